// file: pei_pkg.sv
/*
  Constants, field layout and state types for the time-unit event
  interrupt bank. Assumes one 50 MHz core clock shared by every user.
*/
package pei_pkg;

  // ****************************************************************
  // Register map and field positions
  // ****************************************************************
  localparam int             PEI_ADDR_W       = 12;
  localparam logic [11:0]    PEI_STS_EN_OFS   = 12'h198;
  localparam logic [11:0]    PEI_PIN_CTRL_OFS = 12'h1F0;
  localparam int             PEI_NSRC         = 9;
  localparam int             PEI_NPIN         = 2;
  localparam int             PEI_NPORT_EV     = 6;
  localparam int             PEI_STS_LSB      = 0;
  localparam int             PEI_EN_LSB       = 16;
  localparam int             PEI_SUMMARY_BIT  = 29;
  localparam int             PEI_TIMER_BIT    = 0;
  localparam int             PEI_PIN8_BIT     = 1;
  localparam int             PEI_PIN9_BIT     = 2;
  localparam int             PEI_PORT_LSB     = 3;
  localparam int             PEI_P0_RX_BIT    = 4;
  localparam int             PEI_P2_RX_BIT    = 8;
  localparam int             PEI_CTRL_W       = 6;
  localparam int             PEI_MODE_LSB     = 0;
  localparam int             PEI_CLR_LSB      = 4;
  localparam int             PEI_POL_LSB      = 6;
  localparam int             PEI_CTRL_REG_W   = 8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [8:0]     PEI_STATUS_RST   = 9'h000;
  localparam logic [8:0]     PEI_ENABLE_RST   = 9'h000;
  localparam logic [7:0]     PEI_CTRL_RST     = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int             PEI_CLK_MHZ      = 50;
  localparam int             PEI_QUAL_NS      = 40;
  // Strictly longer than the figure, so one sample more than it covers
  localparam int             PEI_QUAL_CYC     = (PEI_QUAL_NS * PEI_CLK_MHZ) / 1000 + 1;
  localparam int             PEI_PULSE_NS     = 100;
  localparam int             PEI_PULSE_CYC    = (PEI_PULSE_NS * PEI_CLK_MHZ) / 1000;
  localparam int             PEI_PULSE_W      = 3;

  typedef enum logic [1:0] {
    PEI_MODE_PULSE  = 2'h0,
    PEI_MODE_TOGGLE = 2'h1,
    PEI_MODE_LEVEL  = 2'h2,
    PEI_MODE_RSVD   = 2'h3
  } pei_mode_t;

  typedef struct packed {
    logic [8:0]                    status;
    logic [8:0]                    enable;
    logic [7:0]                    ctrl;
    logic                          ge_d;
    logic                          summary;
    logic [1:0]                    pin_out;
    logic [1:0]                    toggle;
    logic [1:0][PEI_PULSE_W-1:0]   pulse_cnt;
    logic [31:0]                   rdata;
  } pei_bank_state_t;

endpackage

// file: pei_pin_if.sv
/*
  Carrier between the bank and its pin qualifier: polarity going out,
  qualified edge pulses coming back. Both ends run on the core clock.
*/
`timescale 1ns/10ps
interface pei_pin_if;
  logic [1:0] active_low;
  logic [1:0] qual;
  modport qualifier (input active_low, output qual);
  modport bank      (output active_low, input qual);
endinterface

// file: pei_pin_qual.sv
/*
  Capture pin qualifier: synchronises each pin, and emits one pulse per
  active edge once the level has held long enough. Assumes raw pins are
  asynchronous to the core clock.
*/
`timescale 1ns/10ps
module pei_pin_qual
  import pei_pkg::*;
#(
  parameter int NPIN     = PEI_NPIN,
  parameter int QUAL_CYC = PEI_QUAL_CYC
) (
  // Clock and reset
  input wire logic            clk,
  input wire logic            rst,
  // Raw pins
  input wire logic [NPIN-1:0] pin_raw,
  // To the bank
  pei_pin_if.qualifier        pif
);
  localparam int CW = $clog2(QUAL_CYC + 1);

  typedef struct packed {
    logic [NPIN-1:0]         sync1;
    logic [NPIN-1:0]         sync2;
    logic [NPIN-1:0]         qual;
    logic [NPIN-1:0][CW-1:0] cnt;
  } pei_qual_state_t;

  pei_qual_state_t r;
  pei_qual_state_t next_r;
  logic [NPIN-1:0] act;

  assign act      = r.sync2 ^ pif.active_low;
  assign pif.qual = r.qual;

  always_comb begin
    next_r       = r;
    next_r.sync1 = pin_raw;
    next_r.sync2 = r.sync1;
    for (int i = 0; i < NPIN; i++) begin
      if (!act[i]) begin
        // Rearm only after the pin goes inactive: edge, not level
        next_r.cnt[i]  = '0;
        next_r.qual[i] = 1'b0;
      end else begin
        next_r.qual[i] = (r.cnt[i] == CW'(QUAL_CYC - 1));
        if (r.cnt[i] != CW'(QUAL_CYC)) begin
          next_r.cnt[i] = r.cnt[i] + CW'(1);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  AST_QUAL_HELD: assert property (@(posedge clk) disable iff (rst)
    r.qual[0] |-> $past(act[0], 1) && $past(act[0], 2) && $past(act[0], 3))
    else $error("Pin 8 qualified without three active samples");

endmodule

// file: pei_bank.sv
/*
  Time-unit event interrupt bank: nine sticky event flags, their enables,
  one summary level and the pin event outputs. Assumes event inputs and
  the time value are on the core clock; capture pins are asynchronous.
*/
`timescale 1ns/10ps

module pei_bank
  import pei_pkg::*;
(
  // Clock and reset
  input  wire logic                  CORE_CLK,
  input  wire logic                  RST,
  // Register port
  input  wire logic [PEI_ADDR_W-1:0] REG_ADDR,
  input  wire logic [31:0]           REG_WDATA,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  output logic [31:0]                REG_RDATA,
  // Packet capture pulses, bit 5 port 2 receive down to bit 0 port 0 transmit
  input  wire logic [5:0]            PORT_CAPTURE,
  // Time value and compare target
  input  wire logic [63:0]           TIME_NOW,
  input  wire logic [63:0]           CLOCK_TARGET,
  // Capture pins, bit 1 pin 9, bit 0 pin 8
  input  wire logic [1:0]            PIN_IN,
  output logic [1:0]                 PIN_CAPTURE_STROBE,
  output logic [1:0]                 PIN_EVENT_OUT,
  // Summary towards the system interrupt status
  output logic                       TIME_UNIT_SUMMARY_STATUS
);

  // ****************************************************************
  // State
  // ****************************************************************
  pei_bank_state_t r;
  pei_bank_state_t next_r;
  pei_pin_if       pif ();
  logic            ge;
  logic            timer_rise;
  logic            sts_wr;
  logic            ctrl_wr;

  pei_pin_qual #(
    .NPIN     (PEI_NPIN),
    .QUAL_CYC (PEI_QUAL_CYC)
  ) u_qual (
    .clk     (CORE_CLK),
    .rst     (RST),
    .pin_raw (PIN_IN),
    .pif     (pif)
  );

  assign pif.active_low = r.ctrl[PEI_POL_LSB +: PEI_NPIN];
  // Compare is registered as an edge so a cleared flag is not relatched
  assign ge         = (TIME_NOW >= CLOCK_TARGET);
  assign timer_rise = ge & ~r.ge_d;
  assign sts_wr     = REG_WR && (REG_ADDR == PEI_STS_EN_OFS);
  assign ctrl_wr    = REG_WR && (REG_ADDR == PEI_PIN_CTRL_OFS);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [8:0] set;
    logic [8:0] clr;
    pei_mode_t  mode;
    set    = '0;
    clr    = '0;
    mode   = PEI_MODE_PULSE;
    next_r = r;
    next_r.ge_d = ge;

    if (sts_wr) begin
      next_r.enable = REG_WDATA[PEI_EN_LSB +: PEI_NSRC];
      clr           = REG_WDATA[PEI_STS_LSB +: PEI_NSRC];
    end
    if (ctrl_wr) begin
      next_r.ctrl = {2'h0, REG_WDATA[PEI_CTRL_W-1:0]};
    end
    if (|(pif.qual & r.ctrl[PEI_CLR_LSB +: PEI_NPIN])) begin
      clr[PEI_TIMER_BIT] = 1'b1;
    end

    // Port 0 receive is fabric-to-host traffic, transmit is host-to-fabric
    set[PEI_PORT_LSB +: PEI_NPORT_EV] = PORT_CAPTURE;
    set[PEI_PIN8_BIT]                 = pif.qual[0];
    set[PEI_PIN9_BIT]                 = pif.qual[1];
    set[PEI_TIMER_BIT]                = timer_rise;

    // Set is ORed last so an event in the clearing cycle survives
    next_r.status  = (r.status & ~clr) | set;
    next_r.summary = |(next_r.status & next_r.enable);

    for (int i = 0; i < PEI_NPIN; i++) begin
      mode = pei_mode_t'(next_r.ctrl[PEI_MODE_LSB + 2*i +: 2]);
      if (timer_rise) begin
        next_r.toggle[i]    = ~r.toggle[i];
        next_r.pulse_cnt[i] = PEI_PULSE_W'(PEI_PULSE_CYC);
      end else if (r.pulse_cnt[i] != '0) begin
        next_r.pulse_cnt[i] = r.pulse_cnt[i] - PEI_PULSE_W'(1);
      end
      case (mode)
        PEI_MODE_PULSE:  next_r.pin_out[i] = (next_r.pulse_cnt[i] != '0);
        PEI_MODE_TOGGLE: next_r.pin_out[i] = next_r.toggle[i];
        PEI_MODE_LEVEL:  next_r.pin_out[i] = next_r.status[PEI_TIMER_BIT];
        default:         next_r.pin_out[i] = 1'b0;
      endcase
    end

    // Read data stands one cycle only; reserved bits stay zero
    next_r.rdata = '0;
    if (REG_RD) begin
      case (REG_ADDR)
        PEI_STS_EN_OFS:   next_r.rdata = {7'h00, r.enable, 7'h00, r.status};
        PEI_PIN_CTRL_OFS: next_r.rdata = {24'h000000, r.ctrl};
        default:          next_r.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      r         <= '0;
      r.status  <= PEI_STATUS_RST;
      r.enable  <= PEI_ENABLE_RST;
      r.ctrl    <= PEI_CTRL_RST;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign REG_RDATA                = r.rdata;
  assign PIN_EVENT_OUT            = r.pin_out;
  assign PIN_CAPTURE_STROBE       = pif.qual;
  assign TIME_UNIT_SUMMARY_STATUS = r.summary;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  AST_W1C_CLEARS: assert property (
    sts_wr && REG_WDATA[PEI_P2_RX_BIT] && !PORT_CAPTURE[5] |=> !r.status[PEI_P2_RX_BIT])
    else $error("Write one did not clear port 2 receive flag");

  AST_FLAG_HOLDS: assert property (
    r.status[PEI_P0_RX_BIT] && !(sts_wr && REG_WDATA[PEI_P0_RX_BIT])
    |=> r.status[PEI_P0_RX_BIT])
    else $error("Flag dropped without a clear");

  AST_SUMMARY_OR: assert property (
    ##1 TIME_UNIT_SUMMARY_STATUS == |(r.status & r.enable))
    else $error("Summary does not match enabled flags");

  AST_MASK_EXCLUDES: assert property (
    sts_wr && (REG_WDATA[PEI_EN_LSB +: PEI_NSRC] == 9'h000) |=> !TIME_UNIT_SUMMARY_STATUS)
    else $error("Summary raised with all sources disabled");

  AST_SET_MASKED: assert property (
    PORT_CAPTURE[0] && r.enable == 9'h000 |=> r.status[PEI_PORT_LSB])
    else $error("Masked source did not set its flag");

  AST_ENABLE_READ: assert property (
    sts_wr ##1 REG_RD && REG_ADDR == PEI_STS_EN_OFS
    |=> REG_RDATA[24:16] == $past(REG_WDATA[24:16], 2))
    else $error("Enable bits did not read back");

  AST_PORT_SET: assert property (
    PORT_CAPTURE[5] |=> r.status[PEI_P2_RX_BIT])
    else $error("Port 2 receive capture did not set flag");

  AST_PIN_SET: assert property (
    pif.qual[1] |=> r.status[PEI_PIN9_BIT])
    else $error("Pin 9 capture did not set flag");

  AST_TIMER_SET: assert property (
    !r.ge_d && (TIME_NOW >= CLOCK_TARGET) |=> r.status[PEI_TIMER_BIT])
    else $error("Timer flag not set on target reached");

  AST_PIN_CLEARS_TIMER: assert property (
    pif.qual[0] && r.ctrl[PEI_CLR_LSB] && !timer_rise |=> !r.status[PEI_TIMER_BIT])
    else $error("Qualified pin edge did not clear timer flag");

  AST_LEVEL_MODE: assert property (
    r.ctrl[1:0] == PEI_MODE_LEVEL |-> PIN_EVENT_OUT[0] == r.status[PEI_TIMER_BIT])
    else $error("Level mode pin does not follow timer flag");

  AST_SET_WINS: assert property (
    sts_wr && REG_WDATA[PEI_PORT_LSB] && PORT_CAPTURE[0] |=> r.status[PEI_PORT_LSB])
    else $error("Clear beat a simultaneous set");

  AST_RSVD_ZERO: assert property (
    REG_RD |=> REG_RDATA[31:25] == 7'h00 && REG_RDATA[15:9] == 7'h00)
    else $error("Reserved bits read non-zero");

  COV_SUMMARY: cover property (PORT_CAPTURE[3] && r.enable[6] ##1 TIME_UNIT_SUMMARY_STATUS);
  COV_PIN_CAPTURE: cover property (pif.qual[0] ##1 r.status[PEI_PIN8_BIT]);
  COV_TIMER_CLEAR: cover property (r.status[PEI_TIMER_BIT] && pif.qual[1] && r.ctrl[5]);
  COV_SET_CLEAR: cover property (sts_wr && REG_WDATA[8] && PORT_CAPTURE[5]);

endmodule

// file: testbench.sv
/*
  Self-checking bench for the time-unit event bank: register access tasks,
  capture pulses, time compare and capture pins, all driven from here.
  Assumes the bank's own assertions watch its ports during the run.
*/
`timescale 1ns/10ps
module testbench
  import pei_pkg::*;
;
  // ****************************************************************
  // Signals and instance
  // ****************************************************************
  logic        clk;
  logic        rst;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [5:0]  cap;
  logic [63:0] tnow;
  logic [63:0] ttgt;
  logic [1:0]  pin;
  logic [1:0]  stb;
  logic [1:0]  evo;
  logic        summ;
  logic [31:0] s;
  logic [31:0] en;
  int          error_cnt;
  int          checks_done;
  int          stb_cnt;

  pei_bank u_pei_bank (
    .CORE_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .PORT_CAPTURE(cap),
    .TIME_NOW(tnow), .CLOCK_TARGET(ttgt), .PIN_IN(pin),
    .PIN_CAPTURE_STROBE(stb), .PIN_EVENT_OUT(evo), .TIME_UNIT_SUMMARY_STATUS(summ)
  );

  always #10 clk = ~clk;
  always @(posedge clk) if (stb[0] === 1'b1) stb_cnt <= stb_cnt + 1;

  // ****************************************************************
  // Access and compare tasks
  // ****************************************************************
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic chk_reg(input string n, input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(n, e, rdata);
  endtask

  task automatic chk_sum(input logic e);
    chk("summary", {31'h0, e}, {31'h0, summ});
  endtask

  task automatic pulse_cap(input logic [5:0] c);
    @(posedge clk);
    cap <= c;
    @(posedge clk);
    cap <= 6'h00;
  endtask

  // Settle time covers sync, qualify and flag latency
  task automatic hold_pin(input int b, input int n);
    @(posedge clk);
    pin[b] <= 1'b1;
    repeat (n) @(posedge clk);
    pin[b] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic set_time(input logic [63:0] tg, input logic [63:0] t);
    @(posedge clk);
    ttgt <= tg;
    tnow <= t;
    repeat (2) @(posedge clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    addr = 12'h000;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    cap = 6'h00;
    tnow = 64'h0;
    ttgt = 64'hFFFF_FFFF_FFFF_FFFF;
    pin = 2'h0;
    error_cnt = 0;
    checks_done = 0;
    stb_cnt = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk_reg("status_enable", PEI_STS_EN_OFS, 32'h0);
    chk_reg("pin_ctrl", PEI_PIN_CTRL_OFS, 32'h0);
    chk_sum(1'b0);
    wr_reg(PEI_STS_EN_OFS, 32'hFFFF_FFFF);
    chk_reg("status_enable", PEI_STS_EN_OFS, 32'h01FF_0000);
    wr_reg(PEI_STS_EN_OFS, 32'h0);
    // Write and read back to back: the read sees the new enables
    @(posedge clk);
    addr  <= PEI_STS_EN_OFS;
    wdata <= 32'h0155_0000;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    rd    <= 1'b1;
    @(posedge clk);
    rd    <= 1'b0;
    #1;
    chk("write_then_read", 32'h0155_0000, rdata);
    wr_reg(PEI_STS_EN_OFS, 32'h0);
    $display("test reset_and_enables done");
    for (int b = 0; b < 6; b++) begin
      s = 32'h1 << (b + 3);
      en = 32'h1 << (b + 19);
      pulse_cap(6'h01 << b);
      chk_reg("port_flag", PEI_STS_EN_OFS, s);
      chk_sum(1'b0);
      wr_reg(PEI_STS_EN_OFS, en);
      chk_reg("flag_kept", PEI_STS_EN_OFS, s | en);
      chk_sum(1'b1);
      wr_reg(PEI_STS_EN_OFS, s | en);
      chk_reg("flag_cleared", PEI_STS_EN_OFS, en);
      chk_sum(1'b0);
      wr_reg(PEI_STS_EN_OFS, 32'h0);
    end
    pulse_cap(6'h01);
    @(posedge clk);
    cap   <= 6'h01;
    addr  <= PEI_STS_EN_OFS;
    wdata <= 32'h0000_0008;
    wr    <= 1'b1;
    @(posedge clk);
    cap <= 6'h00;
    wr  <= 1'b0;
    chk_reg("set_over_clear", PEI_STS_EN_OFS, 32'h0000_0008);
    wr_reg(PEI_STS_EN_OFS, 32'h0000_0008);
    wr_reg(12'h100, 32'hFFFF_FFFF);
    chk_reg("unmapped", 12'h100, 32'h0);
    chk_reg("after_unmapped", PEI_STS_EN_OFS, 32'h0);
    $display("test port_captures done");
    set_time(64'h1_0000_0000, 64'h0_FFFF_FFFF);
    chk_reg("timer_below", PEI_STS_EN_OFS, 32'h0);
    set_time(64'h1_0000_0000, 64'h1_0000_0000);
    chk_reg("timer_equal", PEI_STS_EN_OFS, 32'h1);
    wr_reg(PEI_STS_EN_OFS, 32'h1);
    chk_reg("timer_cleared", PEI_STS_EN_OFS, 32'h0);
    set_time(64'h1_0000_0000, 64'h0);
    set_time(64'h1_0000_0000, 64'h2_0000_0000);
    chk_reg("timer_above", PEI_STS_EN_OFS, 32'h1);
    $display("test timer done");
    hold_pin(0, 2);
    chk_reg("short_pin", PEI_STS_EN_OFS, 32'h1);
    hold_pin(0, 6);
    chk_reg("pin8_flag", PEI_STS_EN_OFS, 32'h3);
    chk("strobe_count", 32'h1, 32'(stb_cnt));
    hold_pin(1, 6);
    chk_reg("pin9_flag", PEI_STS_EN_OFS, 32'h7);
    wr_reg(PEI_STS_EN_OFS, 32'h7);
    $display("test pins done");
    wr_reg(PEI_PIN_CTRL_OFS, 32'hFF);
    chk_reg("pin_ctrl", PEI_PIN_CTRL_OFS, 32'h3F);
    // Pin 8 in level mode, and its edge clears the timer flag
    wr_reg(PEI_PIN_CTRL_OFS, 32'h12);
    set_time(64'h1_0000_0000, 64'h0);
    set_time(64'h1_0000_0000, 64'h1_0000_0000);
    chk_reg("timer_set", PEI_STS_EN_OFS, 32'h1);
    chk("level_out", 32'h1, {31'h0, evo[0]});
    chk("pulse_out", 32'h1, {31'h0, evo[1]});
    hold_pin(0, 6);
    chk("pulse_ended", 32'h0, {31'h0, evo[1]});
    chk_reg("pin_clears_timer", PEI_STS_EN_OFS, 32'h2);
    chk("level_out", 32'h0, {31'h0, evo[0]});
    $display("test timer_clear_and_level done");
    print_verdict();
  end

  // Whole sequence takes well under a thousand cycles
  initial begin
    #400000;
    error_cnt++;
    print_verdict();
  end
endmodule
